// file: hw/psc_params.svh
// constants for the parallel signal change detector
`ifndef PSC_PARAMS_SVH
`define PSC_PARAMS_SVH

`define PSC_ADDR_W 8
`define PSC_DATA_W 8
`define PSC_SIG_W 4
`define PSC_OFS_FALL_EN 8'h2c
`define PSC_OFS_RISE_EN 8'h2d
`define PSC_OFS_STATUS 8'h2f
`define PSC_RST_FALL_EN 4'h0
`define PSC_RST_RISE_EN 4'h0
`define PSC_RST_STATUS 4'h0
`define PSC_RST_SIG 4'h0
`define PSC_UPPER_ZERO 4'h0
`define PSC_NO_LINES 4'h0
`define PSC_RST_IRQ 1'h0
`define PSC_DIR_RISE 1'h1
`define PSC_DIR_FALL 1'h0

`endif

// file: hw/psc_pkg.sv
// types shared by the parallel signal change detector
package psc_pkg;
  // bit 3 negotiation active, 2 init, 1 host busy, 0 host strobe
  typedef struct packed {
    logic negotiation_active_input;
    logic init_input;
    logic host_busy_input;
    logic host_strobe_input;
  } psc_sig_s;
endpackage

// file: hw/psc_detect.sv
// edge detection, status latching and signal-change interrupt for the parallel port inputs
`include "psc_params.svh"

module psc_detect
  import psc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic manual_mode,
  input wire logic signal_change_irq_enable,
  input wire psc_sig_s sig_in,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`PSC_ADDR_W-1:0] reg_addr,
  input wire logic [`PSC_DATA_W-1:0] reg_wdata,
  output logic [`PSC_DATA_W-1:0] reg_rdata_ff,
  output logic signal_change_irq_ff
);

  // ==========================================================
  // helpers
  // enabled lines that moved in the chosen direction since the last sample
  function automatic logic [`PSC_SIG_W-1:0] edge_hits(
    input logic [`PSC_SIG_W-1:0] now_lvl,
    input logic [`PSC_SIG_W-1:0] old_lvl,
    input logic [`PSC_SIG_W-1:0] enable,
    input logic rising
  );
    if (rising) begin
      edge_hits = now_lvl & ~old_lvl & enable;
    end else begin
      edge_hits = ~now_lvl & old_lvl & enable;
    end
  endfunction

  function automatic logic addr_is(
    input logic [`PSC_ADDR_W-1:0] addr,
    input logic [`PSC_ADDR_W-1:0] ofs
  );
    addr_is = (addr == ofs);
  endfunction

  // ==========================================================
  // input sampling
  psc_sig_s sig_prev_ff;
  logic [`PSC_SIG_W-1:0] rising_edge_enable_ff;
  logic [`PSC_SIG_W-1:0] falling_edge_enable_ff;
  logic [`PSC_SIG_W-1:0] signal_change_status_ff;
  logic [`PSC_SIG_W-1:0] rise_hit;
  logic [`PSC_SIG_W-1:0] fall_hit;
  logic [`PSC_SIG_W-1:0] nxt_status;
  logic wr_fall;
  logic wr_rise;
  logic wr_status;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      // load the live levels so a line resting high gives no false edge after reset
      sig_prev_ff <= sig_in;
    end else begin
      sig_prev_ff <= sig_in;
    end
  end

  prev_track_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sig_prev_ff == $past(sig_in))
    else $error("edge history does not follow the inputs");

  assign rise_hit = edge_hits(sig_in, sig_prev_ff, rising_edge_enable_ff, `PSC_DIR_RISE);
  assign fall_hit = edge_hits(sig_in, sig_prev_ff, falling_edge_enable_ff, `PSC_DIR_FALL);

  // ==========================================================
  // register writes
  assign wr_fall = reg_wr && addr_is(reg_addr, `PSC_OFS_FALL_EN);
  assign wr_rise = reg_wr && addr_is(reg_addr, `PSC_OFS_RISE_EN);
  assign wr_status = reg_wr && addr_is(reg_addr, `PSC_OFS_STATUS);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      falling_edge_enable_ff <= `PSC_RST_FALL_EN;
    end else if (wr_fall) begin
      // upper bits are not stored, so they always read back zero
      falling_edge_enable_ff <= reg_wdata[`PSC_SIG_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rising_edge_enable_ff <= `PSC_RST_RISE_EN;
    end else if (wr_rise) begin
      rising_edge_enable_ff <= reg_wdata[`PSC_SIG_W-1:0];
    end
  end

  // ==========================================================
  // status latching: in manual mode, a new edge in the clearing cycle survives the clear
  always_comb begin
    nxt_status = wr_status ? `PSC_RST_STATUS : signal_change_status_ff;
    if (manual_mode) begin
      nxt_status = nxt_status | rise_hit | fall_hit;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      signal_change_status_ff <= `PSC_RST_STATUS;
    end else begin
      signal_change_status_ff <= nxt_status;
    end
  end

  // ==========================================================
  // interrupt: one-cycle pulse per cycle with an enabled falling edge in manual mode
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      signal_change_irq_ff <= `PSC_RST_IRQ;
    end else begin
      signal_change_irq_ff <= manual_mode && signal_change_irq_enable
                              && (|fall_hit);
    end
  end

  // ==========================================================
  // read data, registered one cycle after the read strobe
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata_ff <= {`PSC_UPPER_ZERO, `PSC_RST_STATUS};
    end else if (reg_rd) begin
      unique case (reg_addr)
        `PSC_OFS_FALL_EN: reg_rdata_ff <= {`PSC_UPPER_ZERO, falling_edge_enable_ff};
        `PSC_OFS_RISE_EN: reg_rdata_ff <= {`PSC_UPPER_ZERO, rising_edge_enable_ff};
        `PSC_OFS_STATUS: reg_rdata_ff <= {`PSC_UPPER_ZERO, signal_change_status_ff};
        default: reg_rdata_ff <= {`PSC_UPPER_ZERO, `PSC_RST_STATUS};
      endcase
    end
  end

  // ==========================================================
  // checks
  upper_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rdata_ff[`PSC_DATA_W-1:`PSC_SIG_W] == `PSC_UPPER_ZERO)
    else $error("upper read bits not zero");

  status_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_status && !manual_mode) |=> signal_change_status_ff == `PSC_RST_STATUS)
    else $error("status not cleared by write");

  status_wipe_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_status && rise_hit == `PSC_NO_LINES && fall_hit == `PSC_NO_LINES)
      |=> signal_change_status_ff == `PSC_RST_STATUS)
    else $error("quiet status write left bits set");

  clear_race_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_status && manual_mode)
      |=> signal_change_status_ff == ($past(rise_hit) | $past(fall_hit)))
    else $error("edge in clearing cycle lost or old bit kept");

  fall_latch_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (manual_mode && |fall_hit)
      |=> ((signal_change_status_ff & $past(fall_hit)) == $past(fall_hit)))
    else $error("falling edge not latched");

  rise_latch_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (manual_mode && |rise_hit)
      |=> ((signal_change_status_ff & $past(rise_hit)) == $past(rise_hit)))
    else $error("rising edge not latched");

  irq_cause_a: assert property (@(posedge mclk) disable iff (!rst_n)
    signal_change_irq_ff |-> $past(manual_mode) && $past(signal_change_irq_enable))
    else $error("interrupt without manual mode and enable");

  irq_edge_a: assert property (@(posedge mclk) disable iff (!rst_n)
    signal_change_irq_ff |-> $past(fall_hit) != `PSC_NO_LINES)
    else $error("interrupt without an enabled falling edge");

  irq_fire_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (manual_mode && signal_change_irq_enable && |fall_hit) |=> signal_change_irq_ff)
    else $error("enabled falling edge gave no interrupt");

  irq_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !manual_mode |=> !signal_change_irq_ff)
    else $error("interrupt outside manual mode");

  no_manual_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!manual_mode && !wr_status) |=> $stable(signal_change_status_ff))
    else $error("status changed outside manual mode");

  status_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!wr_status) |=> ((signal_change_status_ff & $past(signal_change_status_ff))
                      == $past(signal_change_status_ff)))
    else $error("status bit dropped without a write");

  fall_rdback_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_rd && reg_addr == `PSC_OFS_FALL_EN && !wr_fall)
      |=> reg_rdata_ff == {`PSC_UPPER_ZERO, falling_edge_enable_ff})
    else $error("falling enable readback wrong");

  fall_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !wr_fall |=> $stable(falling_edge_enable_ff))
    else $error("falling enable changed without a write");

  rise_rdback_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_rd && addr_is(reg_addr, `PSC_OFS_RISE_EN) && !wr_rise)
      |=> reg_rdata_ff == {`PSC_UPPER_ZERO, rising_edge_enable_ff})
    else $error("rising enable readback wrong");

  rise_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !wr_rise |=> $stable(rising_edge_enable_ff))
    else $error("rising enable changed without a write");

  stat_rdback_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_rd && addr_is(reg_addr, `PSC_OFS_STATUS))
      |=> reg_rdata_ff == {`PSC_UPPER_ZERO, $past(signal_change_status_ff)})
    else $error("status readback wrong");

  unmapped_rd_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_rd && !addr_is(reg_addr, `PSC_OFS_FALL_EN) && !addr_is(reg_addr, `PSC_OFS_RISE_EN)
      && !addr_is(reg_addr, `PSC_OFS_STATUS)) |=> reg_rdata_ff == {`PSC_UPPER_ZERO, `PSC_NO_LINES})
    else $error("unmapped read not zero");

  rdata_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !reg_rd |=> $stable(reg_rdata_ff))
    else $error("read data changed without a read");

endmodule // psc_detect

// file: tb/psc_host_model.sv
// host-side model driving the four monitored parallel port control lines
module psc_host_model
  import psc_pkg::*;
(
  input wire logic mclk,
  input wire logic [3:0] want,
  output psc_sig_s sig_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial sig_in = '0;
  // lines move only at the clock edge, like a synchronous host
  always @(posedge mclk) sig_in <= want;
endmodule // psc_host_model

// file: tb/parallel_signal_change_detect_tb.sv
// random self-checking bench for the parallel signal change detector
module parallel_signal_change_detect_tb;
  import psc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst_n = 0, manual_mode = 0, signal_change_irq_enable = 0;
  logic reg_wr = 0, reg_rd = 0, signal_change_irq_ff, e_irq;
  logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata_ff, e_rd;
  logic [3:0] want = '0, e_fall, e_rise, e_stat, e_prev;
  logic [31:0] r;
  psc_sig_s sig_in;
  int seed = 32'hea4d;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  always #5 mclk = ~mclk;
  psc_host_model u_psc_host_model (.mclk(mclk), .want(want), .sig_in(sig_in));
  psc_detect u_psc_detect (.mclk(mclk), .rst_n(rst_n), .manual_mode(manual_mode),
    .signal_change_irq_enable(signal_change_irq_enable), .sig_in(sig_in),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_ff(reg_rdata_ff), .signal_change_irq_ff(signal_change_irq_ff));
  function automatic logic [7:0] rd_val(logic [7:0] a);
    case (a)
      8'h2c: return {4'h0, e_fall};
      8'h2d: return {4'h0, e_rise};
      8'h2f: return {4'h0, e_stat};
      default: return 8'h00;
    endcase
  endfunction
  task check(string name, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task conclude;
    if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================
  // reference model and comparisons
  always @(posedge mclk) begin
    if (rst_n) begin
      check("irq", {7'h0, signal_change_irq_ff}, {7'h0, e_irq});
      check("rdata_hi", {4'h0, reg_rdata_ff[7:4]}, 8'h00);
      check("rdata", reg_rdata_ff, e_rd);
    end
    // edge history follows the lines even in reset, so no false edge on release
    e_prev <= sig_in;
    if (!rst_n) begin
      {e_irq, e_rd, e_fall, e_rise, e_stat} <= '0;
    end else begin
      e_irq <= manual_mode & signal_change_irq_enable & |(e_fall & e_prev & ~sig_in);
      e_stat <= ((reg_wr && reg_addr == 8'h2f) ? 4'h0 : e_stat) | (manual_mode ?
        ((e_rise & sig_in & ~e_prev) | (e_fall & e_prev & ~sig_in)) : 4'h0);
      if (reg_wr && reg_addr == 8'h2c) e_fall <= reg_wdata[3:0];
      if (reg_wr && reg_addr == 8'h2d) e_rise <= reg_wdata[3:0];
      if (reg_rd) e_rd <= rd_val(reg_addr);
    end
  end
  // ==========================================
  // cycle limit, counted as a mismatch
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 5000) begin
      num_errors++;
      conclude();
    end
  end
  // ==========================================
  // stimulus: corner cases, then random traffic with a one-cycle reset in mid-run
  task step(input logic wr, input logic rd, input logic [7:0] addr, input logic [7:0] wd,
            input logic [3:0] w, input logic man, input logic ien);
    reg_wr <= wr;
    reg_rd <= rd;
    reg_addr <= addr;
    reg_wdata <= wd;
    want <= w;
    manual_mode <= man;
    signal_change_irq_enable <= ien;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1;
    // enables on, lines fall, clear lands with the falls, read beside write, no manual mode
    @(posedge mclk) step(1'h1, 1'h0, 8'h2c, 8'h0f, 4'hf, 1'h1, 1'h1);
    @(posedge mclk) step(1'h1, 1'h0, 8'h2d, 8'h0f, 4'hf, 1'h1, 1'h1);
    @(posedge mclk) step(1'h0, 1'h0, 8'h00, 8'h00, 4'h0, 1'h1, 1'h1);
    @(posedge mclk) step(1'h1, 1'h1, 8'h2f, 8'h00, 4'h0, 1'h1, 1'h1);
    @(posedge mclk) step(1'h0, 1'h1, 8'h2f, 8'h00, 4'h0, 1'h1, 1'h0);
    @(posedge mclk) step(1'h0, 1'h1, 8'h2e, 8'h00, 4'hf, 1'h0, 1'h1);
    @(posedge mclk) step(1'h1, 1'h1, 8'h2f, 8'h00, 4'h0, 1'h0, 1'h1);
    @(posedge mclk) step(1'h0, 1'h1, 8'h2f, 8'h00, 4'h0, 1'h1, 1'h1);
    for (int i = 0; i < 3000; i++) begin
      @(posedge mclk);
      r = $random(seed);
      rst_n <= (i != 1500);
      step(r[7:5] == 3'h0, r[8] | signal_change_irq_ff,
        signal_change_irq_ff ? 8'h2f : 8'h2c + {6'h0, r[10:9]}, {4'h0, r[15:12]},
        r[23:20], r[25:24] != 2'h0, r[26]);
    end
    conclude();
  end
endmodule // parallel_signal_change_detect_tb
